// ===== rtl/ppe_pkg.sv
// Constants and types for the front-panel parameter editor
package ppe_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int HOLD_MS = 1000;
  localparam int SHOW_MS = 500;
  localparam int BACK_MS = 10000;
  localparam int BLANK_MS = 200;
  localparam int DEB_MS = 10;
  localparam int RDLY_MS = 500;
  localparam int RPT_MS = 100;
  localparam int HOLD_CYC = HOLD_MS * CYC_PER_MS;
  localparam int SHOW_CYC = SHOW_MS * CYC_PER_MS;
  localparam int BACK_CYC = BACK_MS * CYC_PER_MS;
  localparam int BLANK_CYC = BLANK_MS * CYC_PER_MS;
  localparam int DEB_CYC = DEB_MS * CYC_PER_MS;
  localparam int RDLY_CYC = RDLY_MS * CYC_PER_MS;
  localparam int RPT_CYC = RPT_MS * CYC_PER_MS;
  localparam int CNT_W = 32;
  localparam int NSW = 4;
  localparam int NMODE = 36;
  localparam int MODE_W = 6;
  localparam int DATA_W = 14;
  localparam int SPD_W = 17;
  localparam int NDIG = 5;
  localparam int BCD_W = 4 * NDIG;
  localparam int SEG_W = 7;
  localparam int NSELF = 8;
  localparam logic [MODE_W-1:0] MODE_SPEED = 6'h00;
  localparam logic [MODE_W-1:0] MODE_LAST = 6'h23;
  localparam logic [DATA_W-1:0] DATA_MAX = 14'h270f;
  localparam logic [DATA_W-1:0] DATA_RST = 14'h0000;
  // Switch positions
  localparam int SW_MODE = 0;
  localparam int SW_UP = 1;
  localparam int SW_DOWN = 2;
  localparam int SW_SET = 3;
  // Alarm numbers and output codes
  localparam logic [4:0] AL_NONE = 5'h00;
  localparam logic [4:0] AL_DRAM = 5'h0d;
  localparam logic [4:0] AL_SELF0 = 5'h10;
  localparam logic [4:0] AL_SPDOFS = 5'h16;
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_DRAM = 4'hd;
  // Display characters
  typedef logic [4:0] ppe_chr_t;
  localparam ppe_chr_t CH_A = 5'h0a;
  localparam ppe_chr_t CH_F = 5'h0f;
  localparam ppe_chr_t CH_8 = 5'h08;
  localparam ppe_chr_t CH_L = 5'h10;
  localparam ppe_chr_t CH_DASH = 5'h11;
  localparam ppe_chr_t CH_BLANK = 5'h12;
  typedef enum logic [2:0] {
    ST_SPEED, ST_UBLANK, ST_USHOW, ST_MODE,
    ST_WAIT, ST_DATA, ST_CBLANK, ST_CSHOW
  } ppe_state_t;
endpackage

// ===== rtl/ppe_switch.sv
// Switch debouncer with single-step and auto-repeat pulses
module ppe_switch
  import ppe_pkg::*;
#(
  parameter int DEB = 1,
  parameter int RDLY = 2,
  parameter int RPT = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Switch
  input wire logic raw,
  output logic level,
  output logic step
);
  logic [CNT_W-1:0] deb_r;
  logic [CNT_W-1:0] rep_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      deb_r <= '0;
      level <= 1'b0;
    end
    else if (raw == level)
      deb_r <= '0;
    else if (deb_r == CNT_W'(DEB - 1))
    begin
      deb_r <= '0;
      level <= raw;
    end
    else
      deb_r <= deb_r + 1'b1;
  end

  // First step on press, then one every RPT after RDLY
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rep_r <= '0;
      step <= 1'b0;
    end
    else
    begin
      step <= 1'b0;
      if (!level)
        rep_r <= '0;
      else if (rep_r == '0)
      begin
        step <= 1'b1;
        rep_r <= rep_r + 1'b1;
      end
      else if (rep_r == CNT_W'(RDLY))
      begin
        step <= 1'b1;
        rep_r <= CNT_W'(RDLY - RPT + 1);
      end
      else
        rep_r <= rep_r + 1'b1;
    end
  end
endmodule

// ===== rtl/ppe_bcd.sv
// Binary to five-digit packed decimal converter
module ppe_bcd
  import ppe_pkg::*;
(
  // Value
  input wire logic [SPD_W-1:0] bin,
  output logic [BCD_W-1:0] bcd
);
  always_comb
  begin
    bcd = '0;
    for (int i = SPD_W - 1; i >= 0; i--)
    begin
      for (int d = 0; d < NDIG; d++)
        if (bcd[4*d +: 4] > 4'h4)
          bcd[4*d +: 4] = bcd[4*d +: 4] + 4'h3;
      bcd = {bcd[BCD_W-2:0], bin[i]};
    end
  end
endmodule

// ===== rtl/ppe_top.sv
// Front-panel parameter editor, display and alarm presenter
// Function
// - All four switches held over one second unlocks parameter access.
// - On unlock, blank then show FFFFF until every switch is released.
// - Motor speed shown on five digits when nothing else is selected.
// - Mode switch on shows parameter mode number as F-XX.
// - Mode on, up press advances mode number by one.
// - Mode on, up held keeps advancing mode number.
// - Mode on, down press steps mode number back by one.
// - Mode on, down held keeps stepping mode number back.
// - Mode released, value shown as four digits after half a second.
// - Ten seconds after value display or its last edit step, return to speed.
// - With all switches off, display finally falls back to speed.
// - Value shown, up press raises it by one, held raises repeatedly.
// - Value shown, down press lowers it by one, held repeatedly.
// - Edited value drives motor control before it is committed.
// - Commit only after commit switch held at least one second.
// - After commit, blank then show 88888.
// - Mode F-00 shows motor speed, not an editable value.
// - Active alarm shown as AL-nn on the seven-segment display.
// - Alarms 1 to 12 give output codes of the same number.
// - Data memory fault raises alarm 13 with output code 13.
// - Self-check faults raise alarms 16 to 23.
// - Alarm 22 reports on output code 13.
module ppe_top
  import ppe_pkg::*;
#(
  parameter int P_HOLD = HOLD_CYC,
  parameter int P_SHOW = SHOW_CYC,
  parameter int P_BACK = BACK_CYC,
  parameter int P_BLANK = BLANK_CYC,
  parameter int P_DEB = DEB_CYC,
  parameter int P_RDLY = RDLY_CYC,
  parameter int P_RPT = RPT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Setting switches, high when pressed
  input wire logic sw_mode,
  input wire logic sw_up,
  input wire logic sw_down,
  input wire logic sw_set,
  // Motor speed in rpm
  input wire logic [ppe_pkg::SPD_W-1:0] motor_speed,
  // Alarm sources
  input wire logic [3:0] alarm_core,
  input wire logic dram_fault,
  input wire logic [ppe_pkg::NSELF-1:0] selfchk_fault,
  // Stored parameter load at start-up
  input wire logic nv_load,
  input wire logic [ppe_pkg::MODE_W-1:0] nv_load_addr,
  input wire logic [ppe_pkg::DATA_W-1:0] nv_load_data,
  // Display, digit 4 leftmost, segments gfedcba
  output logic [ppe_pkg::NDIG*ppe_pkg::SEG_W-1:0] seg_r,
  // Working value to motor control
  output logic live_valid_r,
  output logic [ppe_pkg::MODE_W-1:0] live_addr_r,
  output logic [ppe_pkg::DATA_W-1:0] live_data_r,
  // Commit to non-volatile storage
  output logic nv_wr_r,
  output logic [ppe_pkg::MODE_W-1:0] nv_wr_addr_r,
  output logic [ppe_pkg::DATA_W-1:0] nv_wr_data_r,
  // Alarm status
  output logic alarm_on_r,
  output logic [3:0] alarm_code_r,
  output logic unlocked_r
);
  import ppe_pkg::*;

  function automatic logic [SEG_W-1:0] seg7(input ppe_chr_t c);
    case (c)
      5'h00: seg7 = 7'h3f;
      5'h01: seg7 = 7'h06;
      5'h02: seg7 = 7'h5b;
      5'h03: seg7 = 7'h4f;
      5'h04: seg7 = 7'h66;
      5'h05: seg7 = 7'h6d;
      5'h06: seg7 = 7'h7d;
      5'h07: seg7 = 7'h07;
      5'h08: seg7 = 7'h7f;
      5'h09: seg7 = 7'h6f;
      CH_A: seg7 = 7'h77;
      CH_F: seg7 = 7'h71;
      CH_L: seg7 = 7'h38;
      CH_DASH: seg7 = 7'h40;
      default: seg7 = 7'h00;
    endcase
  endfunction

  logic rst_meta_r;
  logic rst_n;
  logic [NSW-1:0] sw_raw;
  logic [NSW-1:0] sw_on;
  logic [NSW-1:0] sw_step;
  ppe_state_t st_r;
  ppe_state_t st_nxt;
  logic [CNT_W-1:0] tmr_r;
  logic [CNT_W-1:0] all_cnt_r;
  logic [CNT_W-1:0] set_cnt_r;
  logic [MODE_W-1:0] mode_r;
  logic [DATA_W-1:0] edit_r;
  logic [DATA_W-1:0] prm_r [NMODE];
  logic all_hit;
  logic set_hit;
  logic up_step;
  logic dn_step;
  logic mode_on;
  logic any_on;
  logic [4:0] alarm_num;
  logic [3:0] alarm_code;
  logic [SPD_W-1:0] bcd_in;
  logic [BCD_W-1:0] bcd;
  ppe_chr_t chr [NDIG];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  assign sw_raw = {sw_set, sw_down, sw_up, sw_mode};

  generate
    for (genvar g = 0; g < NSW; g++)
    begin : g_sw
      ppe_switch #(.DEB(P_DEB), .RDLY(P_RDLY), .RPT(P_RPT)) u_sw (
        .clk(clk),
        .rst_n(rst_n),
        .raw(sw_raw[g]),
        .level(sw_on[g]),
        .step(sw_step[g])
      );
    end
  endgenerate

  assign mode_on = sw_on[SW_MODE];
  assign any_on = |sw_on;
  assign up_step = sw_step[SW_UP] && !sw_on[SW_DOWN];
  assign dn_step = sw_step[SW_DOWN] && !sw_on[SW_UP];
  assign all_hit = all_cnt_r == CNT_W'(P_HOLD);
  assign set_hit = set_cnt_r == CNT_W'(P_HOLD - 1);

  // Hold timers for unlock and commit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      all_cnt_r <= '0;
      set_cnt_r <= '0;
    end
    else
    begin
      if (!(&sw_on))
        all_cnt_r <= '0;
      else if (all_cnt_r <= CNT_W'(P_HOLD))
        all_cnt_r <= all_cnt_r + 1'b1;
      if (sw_raw != NSW'(1 << SW_SET) || sw_on != NSW'(1 << SW_SET))
        set_cnt_r <= '0;
      else if (set_cnt_r < CNT_W'(P_HOLD))
        set_cnt_r <= set_cnt_r + 1'b1;
    end
  end

  always_comb
  begin
    st_nxt = st_r;
    if (all_hit && st_r != ST_UBLANK && st_r != ST_USHOW)
      st_nxt = ST_UBLANK;
    else
      case (st_r)
        ST_SPEED:
          if (mode_on)
            st_nxt = ST_MODE;
        ST_UBLANK:
          if (tmr_r == CNT_W'(P_BLANK - 1))
            st_nxt = ST_USHOW;
        ST_USHOW:
          if (!any_on)
            st_nxt = ST_SPEED;
        ST_MODE:
          if (!mode_on)
            st_nxt = unlocked_r ? ST_WAIT : ST_SPEED;
        ST_WAIT:
          if (mode_on)
            st_nxt = ST_MODE;
          else if (tmr_r == CNT_W'(P_SHOW - 1))
            st_nxt = ST_DATA;
        ST_DATA:
          if (mode_on)
            st_nxt = ST_MODE;
          else if (set_hit && mode_r != MODE_SPEED)
            st_nxt = ST_CBLANK;
          else if (tmr_r == CNT_W'(P_BACK - 1))
            st_nxt = ST_SPEED;
        ST_CBLANK:
          if (tmr_r == CNT_W'(P_BLANK - 1))
            st_nxt = ST_CSHOW;
        ST_CSHOW:
          if (mode_on)
            st_nxt = ST_MODE;
          else if (tmr_r == CNT_W'(P_BACK - 1))
            st_nxt = ST_SPEED;
        default:
          st_nxt = ST_SPEED;
      endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= ST_SPEED;
    else
      st_r <= st_nxt;
  end

  // State timer restarts on entry and on each edit step
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tmr_r <= '0;
    else if (st_nxt != st_r || (st_r == ST_DATA && (up_step || dn_step)))
      tmr_r <= '0;
    else if (tmr_r != '1)
      tmr_r <= tmr_r + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      unlocked_r <= 1'b0;
    else if (st_nxt == ST_UBLANK)
      unlocked_r <= 1'b1;
  end

  // Mode number selection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_r <= MODE_SPEED;
    else if (st_r == ST_MODE && unlocked_r)
    begin
      if (up_step && mode_r != MODE_LAST)
        mode_r <= mode_r + 1'b1;
      else if (dn_step && mode_r != MODE_SPEED)
        mode_r <= mode_r - 1'b1;
    end
  end

  // Working value edit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      edit_r <= DATA_RST;
    else if (st_r == ST_WAIT && st_nxt == ST_DATA)
      edit_r <= prm_r[mode_r];
    else if (st_r == ST_DATA && mode_r != MODE_SPEED)
    begin
      if (up_step && edit_r != DATA_MAX)
        edit_r <= edit_r + 1'b1;
      else if (dn_step && edit_r != DATA_RST)
        edit_r <= edit_r - 1'b1;
    end
  end

  // Stored parameter copy
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NMODE; i++)
        prm_r[i] <= DATA_RST;
    end
    else if (st_r == ST_DATA && st_nxt == ST_CBLANK)
      prm_r[mode_r] <= edit_r;
    else if (nv_load && nv_load_addr <= MODE_LAST)
      prm_r[nv_load_addr] <= nv_load_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nv_wr_r <= 1'b0;
      nv_wr_addr_r <= MODE_SPEED;
      nv_wr_data_r <= DATA_RST;
    end
    else
    begin
      nv_wr_r <= st_r == ST_DATA && st_nxt == ST_CBLANK;
      nv_wr_addr_r <= mode_r;
      nv_wr_data_r <= edit_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      live_valid_r <= 1'b0;
      live_addr_r <= MODE_SPEED;
      live_data_r <= DATA_RST;
    end
    else
    begin
      live_valid_r <= st_r == ST_DATA && mode_r != MODE_SPEED;
      live_addr_r <= mode_r;
      live_data_r <= edit_r;
    end
  end

  // Alarm priority: core, data memory, then self-checks
  always_comb
  begin
    alarm_num = AL_NONE;
    alarm_code = CODE_NONE;
    for (int i = NSELF - 1; i >= 0; i--)
      if (selfchk_fault[i])
      begin
        alarm_num = AL_SELF0 + 5'(i);
        alarm_code = (AL_SELF0 + 5'(i) == AL_SPDOFS) ? CODE_DRAM : CODE_NONE;
      end
    if (dram_fault)
    begin
      alarm_num = AL_DRAM;
      alarm_code = CODE_DRAM;
    end
    if (alarm_core != CODE_NONE)
    begin
      alarm_num = {1'b0, alarm_core};
      alarm_code = alarm_core;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarm_on_r <= 1'b0;
      alarm_code_r <= CODE_NONE;
    end
    else
    begin
      alarm_on_r <= alarm_num != AL_NONE;
      alarm_code_r <= alarm_code;
    end
  end

  ppe_bcd u_bcd (
    .bin(bcd_in),
    .bcd(bcd)
  );

  // Display composition
  always_comb
  begin
    bcd_in = motor_speed;
    for (int d = 0; d < NDIG; d++)
      chr[d] = ppe_chr_t'(bcd[4*d +: 4]);
    if (alarm_num != AL_NONE)
    begin
      bcd_in = SPD_W'(alarm_num);
      chr[4] = CH_A;
      chr[3] = CH_L;
      chr[2] = CH_DASH;
    end
    else
      case (st_r)
        ST_UBLANK, ST_CBLANK:
          for (int d = 0; d < NDIG; d++)
            chr[d] = CH_BLANK;
        ST_USHOW:
          for (int d = 0; d < NDIG; d++)
            chr[d] = CH_F;
        ST_CSHOW:
          for (int d = 0; d < NDIG; d++)
            chr[d] = CH_8;
        ST_MODE, ST_WAIT:
        begin
          bcd_in = SPD_W'(mode_r);
          chr[4] = CH_BLANK;
          chr[3] = CH_F;
          chr[2] = CH_DASH;
        end
        ST_DATA:
          if (mode_r != MODE_SPEED)
          begin
            bcd_in = SPD_W'(edit_r);
            chr[4] = CH_BLANK;
          end
        default:
          bcd_in = motor_speed;
      endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      seg_r <= '0;
    else
      for (int d = 0; d < NDIG; d++)
        seg_r[SEG_W*d +: SEG_W] <= seg7(chr[d]);
  end

  unlock_grant_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == ST_UBLANK && $past(st_r) != ST_UBLANK) |-> $past(all_cnt_r) == P_HOLD)
    else $error("unlock without full hold");

  unlock_show_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == ST_USHOW && alarm_num == AL_NONE) |=> seg_r == {NDIG{seg7(CH_F)}})
    else $error("unlock confirmation not shown");

  speed_disp_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_n && st_r == ST_SPEED && alarm_num == AL_NONE)
    |=> seg_r[SEG_W-1:0] == seg7(5'($past(motor_speed) % 10)))
    else $error("speed digit wrong");

  mode_up_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == ST_MODE && unlocked_r && up_step && mode_r != MODE_LAST)
    |=> mode_r == $past(mode_r) + 1'b1)
    else $error("mode not advanced");

  mode_down_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == ST_MODE && unlocked_r && dn_step && mode_r != MODE_SPEED)
    |=> mode_r == $past(mode_r) - 1'b1)
    else $error("mode not stepped back");

  data_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == ST_DATA && $past(st_r) != ST_DATA)
    |-> $past(st_r) == ST_WAIT && $past(tmr_r) == P_SHOW - 1)
    else $error("value shown at wrong time");

  back_speed_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == ST_DATA && tmr_r == P_BACK - 1 && !mode_on && !all_hit && !set_hit)
    |=> st_r == ST_SPEED)
    else $error("no return to speed");

  edit_up_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == ST_DATA && mode_r != MODE_SPEED && up_step && edit_r != DATA_MAX)
    |=> edit_r == $past(edit_r) + 1'b1)
    else $error("value not raised");

  edit_down_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == ST_DATA && mode_r != MODE_SPEED && dn_step && edit_r != DATA_RST)
    |=> edit_r == $past(edit_r) - 1'b1)
    else $error("value not lowered");

  live_value_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == ST_DATA && mode_r != MODE_SPEED) |=> live_valid_r && live_data_r == $past(edit_r))
    else $error("edited value not applied");

  commit_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    nv_wr_r |-> st_r == ST_CBLANK && $past(st_r) == ST_DATA
    && $past(set_cnt_r) == P_HOLD - 1)
    else $error("commit without hold");

  alarm_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    (alarm_core != CODE_NONE) |=> alarm_code_r == $past(alarm_core) && alarm_on_r)
    else $error("alarm code mismatch");
endmodule

// ===== dv/ppe_operator.sv
// Operator model pressing the four setting switches, with contact bounce
module ppe_operator
  import ppe_pkg::*;
(
  // Clock
  input wire logic clk,
  // Switch positions the operator intends
  input wire logic [3:0] cmd,
  // Switch contacts
  output logic sw_mode,
  output logic sw_up,
  output logic sw_down,
  output logic sw_set
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] s1_r = 4'h0;
  logic [3:0] s2_r = 4'h0;
  logic [3:0] out_r = 4'h0;
  logic [3:0] chg1;
  logic [3:0] chg2;
  assign chg1 = cmd ^ s1_r;
  assign chg2 = s1_r ^ s2_r;
  // New level, one cycle back at the old level, then settled
  always_ff @(posedge clk)
  begin
    s1_r <= cmd;
    s2_r <= s1_r;
    out_r <= (chg1 & cmd) | (~chg1 & chg2 & s2_r) | (~chg1 & ~chg2 & s1_r);
  end
  assign sw_mode = out_r[SW_MODE];
  assign sw_up = out_r[SW_UP];
  assign sw_down = out_r[SW_DOWN];
  assign sw_set = out_r[SW_SET];
endmodule

// ===== dv/panel_parameter_editor_bench.sv
// Self-checking bench for the front-panel parameter editor
module panel_parameter_editor_bench
  import ppe_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HOLD = 40;
  localparam int SHOW = 20;
  localparam int BACK = 200;
  localparam int BLANK = 8;
  localparam int LIMIT = 8000;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] cmd = 4'h0;
  logic sw_mode, sw_up, sw_down, sw_set;
  logic [SPD_W-1:0] motor_speed = 17'h03039;
  logic [3:0] alarm_core = 4'h0;
  logic dram_fault = 1'b0;
  logic [NSELF-1:0] selfchk_fault = 8'h00;
  logic nv_load = 1'b0;
  logic [MODE_W-1:0] nv_load_addr = 6'h00;
  logic [DATA_W-1:0] nv_load_data = 14'h0000;
  logic [NDIG*SEG_W-1:0] seg_r;
  logic live_valid_r, nv_wr_r, alarm_on_r, unlocked_r;
  logic [MODE_W-1:0] live_addr_r, nv_wr_addr_r;
  logic [DATA_W-1:0] live_data_r, nv_wr_data_r;
  logic [3:0] alarm_code_r;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int wr_cnt = 0;
  logic [MODE_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  int n;

  always #2.5 clk = ~clk;

  ppe_operator op (.clk(clk), .cmd(cmd), .sw_mode(sw_mode), .sw_up(sw_up),
    .sw_down(sw_down), .sw_set(sw_set));

  ppe_top #(.P_HOLD(HOLD), .P_SHOW(SHOW), .P_BACK(BACK), .P_BLANK(BLANK), .P_DEB(3),
    .P_RDLY(20), .P_RPT(6)) dut (.clk(clk), .nrst(nrst), .sw_mode(sw_mode), .sw_up(sw_up),
    .sw_down(sw_down), .sw_set(sw_set), .motor_speed(motor_speed), .alarm_core(alarm_core),
    .dram_fault(dram_fault), .selfchk_fault(selfchk_fault), .nv_load(nv_load),
    .nv_load_addr(nv_load_addr), .nv_load_data(nv_load_data), .seg_r(seg_r),
    .live_valid_r(live_valid_r), .live_addr_r(live_addr_r), .live_data_r(live_data_r),
    .nv_wr_r(nv_wr_r), .nv_wr_addr_r(nv_wr_addr_r), .nv_wr_data_r(nv_wr_data_r),
    .alarm_on_r(alarm_on_r), .alarm_code_r(alarm_code_r), .unlocked_r(unlocked_r));

  // Capture commits
  always @(posedge clk)
  begin
    if (nv_wr_r === 1'b1)
    begin
      wr_cnt++;
      wr_addr = nv_wr_addr_r;
      wr_data = nv_wr_data_r;
    end
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      fail_count++;
      $display("ERROR timeout expected under %0d cycles seen %0d", LIMIT, cyc);
      end_of_test();
    end
  end

  function automatic logic [6:0] seg7(input int c);
    case (c)
      0: return 7'h3f;
      1: return 7'h06;
      2: return 7'h5b;
      3: return 7'h4f;
      4: return 7'h66;
      5: return 7'h6d;
      6: return 7'h7d;
      7: return 7'h07;
      8: return 7'h7f;
      9: return 7'h6f;
      10: return 7'h77;
      15: return 7'h71;
      16: return 7'h38;
      17: return 7'h40;
      default: return 7'h00;
    endcase
  endfunction

  function automatic logic [34:0] pack5(input int a, input int b, input int c, input int d,
                                        input int e);
    return {seg7(a), seg7(b), seg7(c), seg7(d), seg7(e)};
  endfunction

  // Character 18 is a blank digit
  function automatic logic [34:0] mode_disp(input int m);
    return pack5(18, 15, 17, m / 10, m % 10);
  endfunction

  function automatic logic [34:0] val_disp(input int v);
    return pack5(18, v / 1000 % 10, v / 100 % 10, v / 10 % 10, v % 10);
  endfunction

  function automatic logic [34:0] spd_disp(input int v);
    return pack5(v / 10000 % 10, v / 1000 % 10, v / 100 % 10, v / 10 % 10, v % 10);
  endfunction

  task automatic check(input string what, input logic [34:0] exp, input logic [34:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_seg(input string what, input logic [34:0] exp, input int lim,
                          output int k);
    k = 0;
    @(negedge clk);
    while (seg_r !== exp && k < lim)
    begin
      k++;
      @(negedge clk);
    end
    check(what, exp, seg_r);
  endtask

  task automatic put(input logic [3:0] m, input int c);
    @(posedge clk);
    cmd <= m;
    repeat (c) @(posedge clk);
  endtask

  task automatic alarm_case(input logic [3:0] core, input logic dram, input logic [7:0] self,
                            input int al, input logic [3:0] code);
    @(posedge clk);
    alarm_core <= core;
    dram_fault <= dram;
    selfchk_fault <= self;
    repeat (4) @(negedge clk);
    check("alarm code", code, alarm_code_r);
    check("alarm flag", al != 0, alarm_on_r);
    if (al != 0)
      check("alarm display", pack5(10, 16, 17, al / 10, al % 10), seg_r);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic t_locked();
    wait_seg("speed", spd_disp(12345), 10, n);
    put(4'h1, 10);
    wait_seg("locked mode", mode_disp(0), 10, n);
    put(4'h3, 10);
    put(4'h1, 0);
    wait_seg("locked step", mode_disp(0), 10, n);
    put(4'hf, 30);
    put(4'h0, 10);
    check("early unlock", 0, unlocked_r);
    wait_seg("back to speed", spd_disp(12345), 40, n);
    $display("locked test done");
  endtask

  task automatic t_unlock();
    put(4'hf, 0);
    wait_seg("unlock blank", 0, HOLD + 30, n);
    check("unlock time", 1, n >= HOLD);
    check("unlocked", 1, unlocked_r);
    wait_seg("unlock mark", pack5(15, 15, 15, 15, 15), BLANK + 10, n);
    put(4'h0, 0);
    wait_seg("speed again", spd_disp(12345), 20, n);
    $display("unlock test done");
  endtask

  task automatic t_mode();
    put(4'h1, 10);
    wait_seg("mode 0", mode_disp(0), 10, n);
    put(4'h3, 10);
    put(4'h1, 0);
    wait_seg("mode up", mode_disp(1), 20, n);
    put(4'h3, 400);
    put(4'h1, 0);
    wait_seg("mode held up", mode_disp(35), 20, n);
    put(4'h5, 10);
    put(4'h1, 0);
    wait_seg("mode down", mode_disp(34), 20, n);
    put(4'h5, 400);
    put(4'h1, 0);
    wait_seg("mode held down", mode_disp(0), 20, n);
    put(4'h3, 10);
    put(4'h1, 10);
    put(4'h3, 10);
    put(4'h1, 0);
    wait_seg("mode 2", mode_disp(2), 20, n);
    $display("mode test done");
  endtask

  task automatic t_value();
    put(4'h0, 0);
    wait_seg("value shown", val_disp(123), SHOW + 40, n);
    check("value delay", 1, n >= SHOW);
    check("live valid", 1, live_valid_r);
    check("live addr", 2, live_addr_r);
    put(4'h2, 10);
    put(4'h0, 0);
    wait_seg("value up", val_disp(124), 20, n);
    check("live data", 124, live_data_r);
    put(4'h4, 10);
    put(4'h0, 0);
    wait_seg("value down", val_disp(123), 20, n);
    put(4'h4, 850);
    put(4'h0, 0);
    wait_seg("value held down", val_disp(0), 20, n);
    put(4'h2, 10);
    put(4'h0, 0);
    wait_seg("value 1", val_disp(1), 20, n);
    $display("value test done");
  endtask

  task automatic t_commit();
    put(4'h8, 20);
    put(4'h0, 10);
    check("short commit", 0, wr_cnt);
    put(4'h8, 0);
    wait_seg("commit blank", 0, HOLD + 40, n);
    check("commit time", 1, n >= HOLD);
    repeat (3) @(negedge clk);
    check("commit count", 1, wr_cnt);
    check("commit addr", 2, wr_addr);
    check("commit data", 1, wr_data);
    put(4'h0, 0);
    wait_seg("commit mark", pack5(8, 8, 8, 8, 8), BLANK + 20, n);
    wait_seg("after commit", spd_disp(12345), BACK + 20, n);
    put(4'h1, 10);
    put(4'h0, 0);
    wait_seg("stored value", val_disp(1), SHOW + 40, n);
    wait_seg("timeout speed", spd_disp(12345), BACK + 40, n);
    check("timeout length", 1, n >= BACK - 10);
    $display("commit test done");
  endtask

  task automatic t_mode0();
    @(posedge clk);
    motor_speed <= 17'h0d431;
    put(4'h1, 10);
    put(4'h5, 10);
    put(4'h1, 10);
    put(4'h5, 10);
    put(4'h1, 0);
    wait_seg("mode back to 0", mode_disp(0), 20, n);
    put(4'h0, SHOW + 20);
    wait_seg("mode 0 speed", spd_disp(54321), 10, n);
    check("mode 0 not live", 0, live_valid_r);
    $display("mode 0 test done");
  endtask

  task automatic t_alarm();
    for (int i = 1; i <= 12; i++)
      alarm_case(4'(i), 1'b0, 8'h00, i, 4'(i));
    alarm_case(4'h0, 1'b1, 8'h00, 13, 4'hd);
    alarm_case(4'h0, 1'b0, 8'h40, 22, 4'hd);
    alarm_case(4'h0, 1'b0, 8'h01, 16, 4'h0);
    alarm_case(4'h3, 1'b1, 8'hff, 3, 4'h3);
    alarm_case(4'h0, 1'b0, 8'h00, 0, 4'h0);
    $display("alarm test done");
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    nv_load <= 1'b1;
    nv_load_addr <= 6'h02;
    nv_load_data <= 14'h007b;
    @(posedge clk);
    nv_load <= 1'b0;
    t_locked();
    t_unlock();
    t_mode();
    t_value();
    t_commit();
    t_mode0();
    t_alarm();
    end_of_test();
  end
endmodule
